// File: acer_defs.svh
// register offsets, field positions and reset values for the calibration/excite bank
`ifndef ACER_DEFS_SVH
`define ACER_DEFS_SVH
`define ACER_ADDR_OFS_MID   4'h5
`define ACER_ADDR_OFS_HIGH  4'h6
`define ACER_ADDR_GAIN_LOW  4'h7
`define ACER_ADDR_GAIN_MID  4'h8
`define ACER_ADDR_GAIN_HIGH 4'h9
`define ACER_ADDR_EXCITE    4'ha
`define ACER_ADDR_ROUTE     4'hb
`define ACER_ADDR_SHARE     4'hc
`define ACER_ADDR_DIR       4'hd
`define ACER_ADDR_DATA      4'he
`define ACER_RST_OFS        8'h00
`define ACER_RST_ROUTE      8'hff
`define ACER_RST_GPIO       8'h00
`define ACER_RST_LEVEL      3'h0
`define ACER_RST_READY_SEL  1'b0
`define ACER_REV_MSB        7
`define ACER_REV_LSB        4
`define ACER_READY_SEL_BIT  3
`define ACER_LEVEL_MSB      2
`define ACER_OP_READ        4'h2
`define ACER_OP_WRITE       4'h4
`define ACER_OP_NOP         8'hff
`endif

// File: acer_host_model.sv
// host model issuing byte commands and taking read bytes
`default_nettype none
module acer_host_model (
  input  wire logic       clk_i,
  output var logic        cmd_valid_o,
  output var logic  [7:0] cmd_byte_o,
  output var logic        frame_end_o,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_byte_i,
  output var logic        rd_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'hff;
    frame_end_o = 1'b0;
    rd_ready_o = 1'b0;
  end
  // one byte per pulse, bus inverted once released
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_byte_o = b;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~b;
  endtask
  // wait for a byte, stall, then hold ready for one edge
  task automatic take(output logic [7:0] b, output bit ok, input int stall);
    ok = 1'b0;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(negedge clk_i);
      ok = (rd_valid_i === 1'b1);
    end
    repeat (stall) @(negedge clk_i);
    b = rd_byte_i;
    rd_ready_o = ok;
    @(negedge clk_i);
    rd_ready_o = 1'b0;
  endtask
  task automatic abort;
    @(negedge clk_i);
    frame_end_o = 1'b1;
    @(negedge clk_i);
    frame_end_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: acer_pkg.sv
// types for the calibration/excite register bank
`default_nettype none
package acer_pkg;
  typedef enum logic [3:0] {
    ACER_ST_CMD   = 4'b0001,
    ACER_ST_COUNT = 4'b0010,
    ACER_ST_WDATA = 4'b0100,
    ACER_ST_RDATA = 4'b1000
  } acer_state_t;
endpackage
`default_nettype wire

// File: acer_regs.sv
// calibration, excitation and shared-pin register bank with byte command port
// Operation
// - offset coefficient bytes 15:8 at 05h, 23:16 at 06h, reset zero
// - gain coefficient is bytes 07h,08h,09h, low byte at lowest address
// - gain coefficient resets to trimmed value per gain; reloads on gain change
// - revision code in 0Ah bits 7:4, read-only
// - 0Ah bit 3 set lets shared out pin show ready low between transfers
// - dedicated ready pin always shows data availability
// - 0Ah bits 2:0 select excitation current level, zero is off
// - excitation current flows only while internal reference is on
// - 0Bh bits 7:4 route first source: inputs, pin one, two, or off
// - 0Bh bits 3:0 route second source with same encoding
// - routing register resets to FFh, both sources disconnected
// - share bit 0 analog input, 1 general-purpose pin
// - pins 0,1 on reference-0 inputs, pins 2 to 7 on inputs 2 to 7
// - direction bit 0 output, 1 input, for enabled pins
// - enabled output pins drive the written data bit
// - input pins read back their sampled level, updated only once two consecutive samples agree
// - smaller variant keeps bits 3:0 of pin registers, upper read zero
// - one-byte commands stand alone; write takes count then data bytes
// - commands carry 4-bit address and count minus one; don't-cares ignored
// - read is 0010 address, 0000 count, then register bytes returned
// - write is 0100 address, count, one data byte per register
// - multi-register read address wraps from 0Fh to 00h, unused addresses read zero
`default_nettype none
`include "acer_defs.svh"
module acer_regs #(
  parameter int          PIN_COUNT = 8,
  parameter logic [3:0]  REV_CODE  = 4'h1, // arbitrary value
  parameter logic [23:0] GAIN_TRIM_0 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_1 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_2 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_3 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_4 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_5 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_6 = 24'h400000,
  parameter logic [23:0] GAIN_TRIM_7 = 24'h400000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // command byte port
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_byte_i,
  input  wire logic        cmd_frame_end_i,
  output logic             rd_valid_o,
  output logic [7:0]       rd_byte_o,
  input  wire logic        rd_ready_i,
  // system inputs
  input  wire logic [2:0]  gain_sel_i,
  input  wire logic        ref_on_i,
  input  wire logic        data_ready_i,
  input  wire logic        transfer_active_i,
  input  wire logic        serial_out_data_i,
  // serial output pins
  output logic             shared_serial_out_pin_o,
  output logic             conversion_ready_n_o,
  // excitation
  output logic [2:0]       excite_current_level_o,
  output logic [3:0]       first_source_route_o,
  output logic [3:0]       second_source_route_o,
  // coefficients
  output logic [23:0]      offset_correction_coeff_o,
  output logic [23:0]      fullscale_correction_coeff_o,
  // shared pins
  output logic [7:0]       analog_input_select_o,
  input  wire logic [7:0]  gpio_i,
  output logic [7:0]       gpio_o,
  output logic [7:0]       gpio_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    acer_pkg::acer_state_t st;
    logic [3:0]  addr;
    logic [3:0]  cnt;
    logic [7:0]  ofs_mid;
    logic [7:0]  ofs_high;
    logic [23:0] gain;
    logic [2:0]  gain_prev;
    logic        ready_sel;
    logic [2:0]  level;
    logic [7:0]  route;
    logic [7:0]  share;
    logic [7:0]  dir;
    logic [7:0]  dat;
    logic [7:0]  pin_s1;
    logic [7:0]  pin_s2;
    logic [7:0]  pin_s3;
    logic [7:0]  pin_lvl;
    logic        rd_valid;
    logic [7:0]  rd_byte;
    logic        is_read;
  } acer_state_s_t;

  acer_state_s_t s_r;
  acer_state_s_t s_nxt;

  localparam logic [7:0] PIN_MASK = 8'((16'h1 << PIN_COUNT) - 16'h1);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [23:0] gain_trim(input logic [2:0] g);
    case (g)
      3'h0: gain_trim = GAIN_TRIM_0;
      3'h1: gain_trim = GAIN_TRIM_1;
      3'h2: gain_trim = GAIN_TRIM_2;
      3'h3: gain_trim = GAIN_TRIM_3;
      3'h4: gain_trim = GAIN_TRIM_4;
      3'h5: gain_trim = GAIN_TRIM_5;
      3'h6: gain_trim = GAIN_TRIM_6;
      default: gain_trim = GAIN_TRIM_7;
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input acer_state_s_t s, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `ACER_ADDR_OFS_MID) begin
      v = s.ofs_mid;
    end else if (a == `ACER_ADDR_OFS_HIGH) begin
      v = s.ofs_high;
    end else if (a == `ACER_ADDR_GAIN_LOW) begin
      v = s.gain[7:0];
    end else if (a == `ACER_ADDR_GAIN_MID) begin
      v = s.gain[15:8];
    end else if (a == `ACER_ADDR_GAIN_HIGH) begin
      v = s.gain[23:16];
    end else if (a == `ACER_ADDR_EXCITE) begin
      v = {REV_CODE, s.ready_sel, s.level};
    end else if (a == `ACER_ADDR_ROUTE) begin
      v = s.route;
    end else if (a == `ACER_ADDR_SHARE) begin
      v = s.share & PIN_MASK;
    end else if (a == `ACER_ADDR_DIR) begin
      v = s.dir & PIN_MASK;
    end else if (a == `ACER_ADDR_DATA) begin
      v = ((s.dat & ~s.dir) | (s.pin_lvl & s.dir)) & PIN_MASK;
    end
    reg_read = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    // three-stage pin sampling
    s_nxt.pin_s1 = gpio_i;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_s3 = s_r.pin_s2;
    if (s_r.pin_s2 == s_r.pin_s3) begin
      s_nxt.pin_lvl = s_r.pin_s3;
    end
    // gain change reloads trimmed coefficient
    s_nxt.gain_prev = gain_sel_i;
    if (gain_sel_i != s_r.gain_prev) begin
      s_nxt.gain = gain_trim(gain_sel_i);
    end
    // read byte handshake
    if (s_r.rd_valid && rd_ready_i) begin
      s_nxt.rd_valid = 1'b0;
      if (s_r.cnt == 4'h0) begin
        s_nxt.st = acer_pkg::ACER_ST_CMD;
      end else begin
        s_nxt.cnt = s_r.cnt - 4'h1;
        s_nxt.addr = s_r.addr + 4'h1;
      end
    end
    if (s_r.st == acer_pkg::ACER_ST_RDATA && !s_nxt.rd_valid &&
        s_nxt.st == acer_pkg::ACER_ST_RDATA) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_byte = reg_read(s_r, s_nxt.addr);
    end
    // command bytes
    if (cmd_valid_i) begin
      case (s_r.st)
        acer_pkg::ACER_ST_CMD: begin
          s_nxt.addr = cmd_byte_i[3:0];
          s_nxt.is_read = (cmd_byte_i[7:4] == `ACER_OP_READ);
          if (cmd_byte_i[7:4] == `ACER_OP_READ || cmd_byte_i[7:4] == `ACER_OP_WRITE) begin
            s_nxt.st = acer_pkg::ACER_ST_COUNT;
          end
        end
        acer_pkg::ACER_ST_COUNT: begin
          s_nxt.cnt = cmd_byte_i[3:0];
          if (s_r.is_read) begin
            s_nxt.st = acer_pkg::ACER_ST_RDATA;
          end else begin
            s_nxt.st = acer_pkg::ACER_ST_WDATA;
          end
        end
        acer_pkg::ACER_ST_WDATA: begin
          if (s_r.addr == `ACER_ADDR_OFS_MID) begin
            s_nxt.ofs_mid = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_OFS_HIGH) begin
            s_nxt.ofs_high = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_GAIN_LOW) begin
            s_nxt.gain[7:0] = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_GAIN_MID) begin
            s_nxt.gain[15:8] = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_GAIN_HIGH) begin
            s_nxt.gain[23:16] = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_EXCITE) begin
            s_nxt.ready_sel = cmd_byte_i[`ACER_READY_SEL_BIT];
            s_nxt.level = cmd_byte_i[`ACER_LEVEL_MSB:0];
          end else if (s_r.addr == `ACER_ADDR_ROUTE) begin
            s_nxt.route = cmd_byte_i;
          end else if (s_r.addr == `ACER_ADDR_SHARE) begin
            s_nxt.share = cmd_byte_i & PIN_MASK;
          end else if (s_r.addr == `ACER_ADDR_DIR) begin
            s_nxt.dir = cmd_byte_i & PIN_MASK;
          end else if (s_r.addr == `ACER_ADDR_DATA) begin
            s_nxt.dat = cmd_byte_i & PIN_MASK;
          end
          s_nxt.addr = s_r.addr + 4'h1;
          s_nxt.cnt = s_r.cnt - 4'h1;
          if (s_r.cnt == 4'h0) begin
            s_nxt.st = acer_pkg::ACER_ST_CMD;
          end
        end
        default: begin
        end
      endcase
    end
    if (cmd_frame_end_i) begin
      s_nxt.st = acer_pkg::ACER_ST_CMD;
      s_nxt.rd_valid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r <= '0;
      s_r.st <= acer_pkg::ACER_ST_CMD;
      s_r.ofs_mid <= `ACER_RST_OFS;
      s_r.ofs_high <= `ACER_RST_OFS;
      s_r.gain <= GAIN_TRIM_0;
      s_r.ready_sel <= `ACER_RST_READY_SEL;
      s_r.level <= `ACER_RST_LEVEL;
      s_r.route <= `ACER_RST_ROUTE;
      s_r.share <= `ACER_RST_GPIO;
      s_r.dir <= `ACER_RST_GPIO;
      s_r.dat <= `ACER_RST_GPIO;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_valid_o = s_r.rd_valid;
  assign rd_byte_o = s_r.rd_byte;
  assign conversion_ready_n_o = ~data_ready_i;
  assign shared_serial_out_pin_o = transfer_active_i ? serial_out_data_i :
                                   (s_r.ready_sel ? ~data_ready_i : serial_out_data_i);
  assign excite_current_level_o = ref_on_i ? s_r.level : 3'h0;
  assign first_source_route_o = s_r.route[7:4];
  assign second_source_route_o = s_r.route[3:0];
  assign offset_correction_coeff_o = {s_r.ofs_high, s_r.ofs_mid, 8'h00};
  assign fullscale_correction_coeff_o = s_r.gain;
  assign analog_input_select_o = ~(s_r.share & PIN_MASK);
  assign gpio_oe_o = s_r.share & ~s_r.dir & PIN_MASK;
  assign gpio_o = s_r.dat & gpio_oe_o;

endmodule
`default_nettype wire

// File: acer_regs_asserts.sv
// assertion checker for the calibration/excite register bank
`default_nettype none
module acer_regs_chk (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic        cmd_valid_i,
  input wire logic [7:0]  cmd_byte_i,
  input wire logic        rd_valid_o,
  input wire logic [7:0]  rd_byte_o,
  input wire logic        rd_ready_i,
  input wire logic [2:0]  gain_sel_i,
  input wire logic        ref_on_i,
  input wire logic        data_ready_i,
  input wire logic        transfer_active_i,
  input wire logic        serial_out_data_i,
  input wire logic        shared_serial_out_pin_o,
  input wire logic        conversion_ready_n_o,
  input wire logic [2:0]  excite_current_level_o,
  input wire logic [3:0]  first_source_route_o,
  input wire logic [3:0]  second_source_route_o,
  input wire logic [23:0] offset_correction_coeff_o,
  input wire logic [23:0] fullscale_correction_coeff_o,
  input wire logic [7:0]  analog_input_select_o,
  input wire logic [7:0]  gpio_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // read command byte then count byte
  sequence s_read_cmd;
    cmd_valid_i && cmd_byte_i[7:4] == 4'h2 ##[1:2] cmd_valid_i && cmd_byte_i[7:4] == 4'h0;
  endsequence
  a_read_answer: assert property (s_read_cmd |-> ##2 rd_valid_o)
    else $error("read byte not offered after count");
  a_read_hold: assert property (rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_byte_o))
    else $error("read byte dropped before taken");
  a_ready_pin: assert property (conversion_ready_n_o == !data_ready_i)
    else $error("ready pin wrong");
  a_shared_xfer: assert property (transfer_active_i |-> shared_serial_out_pin_o == serial_out_data_i)
    else $error("shared pin not data in transfer");
  a_shared_idle: assert property (!transfer_active_i && shared_serial_out_pin_o != serial_out_data_i
    |-> shared_serial_out_pin_o == !data_ready_i)
    else $error("shared pin shows neither data nor ready");
  a_level_gate: assert property (!ref_on_i |-> excite_current_level_o == 3'h0)
    else $error("current on without reference");
  a_offset_low: assert property (offset_correction_coeff_o[7:0] == 8'h00)
    else $error("offset low byte not zero");
  a_route_reset: assert property ($fell(srst_i) |-> {first_source_route_o, second_source_route_o}
    == 8'hff)
    else $error("routes not disconnected after reset");
  a_gain_reload: assert property ($changed(gain_sel_i) && !cmd_valid_i
    |-> ##[0:2] fullscale_correction_coeff_o == 24'h400000)
    else $error("gain coefficient not reloaded");
  a_pin_no_clash: assert property ((gpio_oe_o & analog_input_select_o) == 8'h00)
    else $error("analog pin driven");
endmodule
bind acer_regs acer_regs_chk i_chk (.clk_i, .srst_i, .cmd_valid_i, .cmd_byte_i, .rd_valid_o,
  .rd_byte_o, .rd_ready_i, .gain_sel_i, .ref_on_i, .data_ready_i, .transfer_active_i,
  .serial_out_data_i, .shared_serial_out_pin_o, .conversion_ready_n_o, .excite_current_level_o,
  .first_source_route_o, .second_source_route_o, .offset_correction_coeff_o,
  .fullscale_correction_coeff_o, .analog_input_select_o, .gpio_oe_o);
`default_nettype wire

// File: acer_regs_tb.sv
// self-checking testbench for the calibration/excite register bank
`default_nettype none
module acer_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] REV = 4'h6; // arbitrary value
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        cmd_valid_i, cmd_frame_end_i, rd_valid_o, rd_ready_i;
  logic        ref_on_i = 1'b1;
  logic        data_ready_i = 1'b0;
  logic        transfer_active_i = 1'b0;
  logic        serial_out_data_i = 1'b0;
  logic        shared_serial_out_pin_o, conversion_ready_n_o;
  logic [2:0]  gain_sel_i = 3'h0;
  logic [2:0]  excite_current_level_o;
  logic [3:0]  first_source_route_o, second_source_route_o;
  logic [7:0]  cmd_byte_i, rd_byte_o, analog_input_select_o, gpio_o, gpio_oe_o, gpio_i, got;
  logic [7:0]  pin_ext = 8'h5a;
  logic [23:0] offset_correction_coeff_o, fullscale_correction_coeff_o;
  bit          ok;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & pin_ext);
  acer_regs #(.REV_CODE(REV)) i_dut (.*);
  acer_host_model i_host (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i),
    .frame_end_o(cmd_frame_end_i), .rd_valid_i(rd_valid_o), .rd_byte_i(rd_byte_o),
    .rd_ready_o(rd_ready_i));
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: read byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: port value %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    i_host.send({4'h4, a});
    i_host.send(8'(d.size() - 1));
    foreach (d[i]) i_host.send(d[i]);
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e[$]);
    i_host.send({4'h2, a});
    i_host.send(8'(e.size() - 1));
    foreach (e[i]) begin
      i_host.take(got, ok, i % 3);
      if (!ok) got = 'x;
      chk_byte(got, e[i]);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    rd(4'h5, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, {REV, 4'h0}, 8'hff, 8'h00, 8'h00, 8'h00});
    wr(4'h5, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'hff, 8'ha9});
    chk_pin(offset_correction_coeff_o, 24'h221100);
    chk_pin(fullscale_correction_coeff_o, 24'h554433);
    chk_pin({first_source_route_o, second_source_route_o}, 24'ha9);
    rd(4'ha, '{{REV, 4'hf}});
    ref_on_i = 1'b0;
    @(negedge clk_i);
    chk_pin(excite_current_level_o, 24'h0);
    ref_on_i = 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(4'ha, '{8'(k)});
      chk_pin(excite_current_level_o, 24'(k));
    end
    wr(4'hd, '{8'h30});
    rd(4'hd, '{8'h30, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11});
    i_host.send(8'h06);
    i_host.send(8'h46);
    i_host.abort();
    rd(4'h5, '{8'h11, 8'h22});
    gain_sel_i = 3'h5;
    repeat (3) @(negedge clk_i);
    chk_pin(fullscale_correction_coeff_o, 24'h400000);
    wr(4'hc, '{8'h0f, 8'h03, 8'ha5});
    chk_pin(analog_input_select_o, 24'hf0);
    chk_pin(gpio_oe_o, 24'h0c);
    chk_pin(gpio_o & gpio_oe_o, 24'h04);
    pin_ext = 8'ha6;
    repeat (5) @(negedge clk_i);
    rd(4'he, '{8'ha6});
    wr(4'ha, '{8'h08});
    data_ready_i = 1'b1;
    serial_out_data_i = 1'b1;
    @(negedge clk_i);
    chk_pin(shared_serial_out_pin_o, 24'h0);
    chk_pin(conversion_ready_n_o, 24'h0);
    transfer_active_i = 1'b1;
    @(negedge clk_i);
    chk_pin(shared_serial_out_pin_o, 24'h1);
    transfer_active_i = 1'b0;
    wr(4'ha, '{8'h00});
    chk_pin(shared_serial_out_pin_o, 24'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
